// ==== common/insn_decode_pkg.sv ====
package insn_decode_pkg;

  // Instruction word field positions
  localparam int COND_HI      = 31;
  localparam int COND_LO      = 28;
  localparam int OPCODE_HI    = 24;
  localparam int OPCODE_LO    = 21;
  localparam int RN_HI        = 19;
  localparam int RN_LO        = 16;
  localparam int RD_HI        = 15;
  localparam int RD_LO        = 12;
  localparam int OP2_HI       = 11;
  localparam int OP2_LO       = 0;
  localparam int ROT_HI       = 11;
  localparam int ROT_LO       = 8;
  localparam int IMM8_HI      = 7;
  localparam int IMM8_LO      = 0;
  localparam int CLASS_HI     = 27;
  localparam int CLASS_LO     = 25;
  localparam int S_BIT        = 20;
  localparam int W_BIT        = 21;
  localparam int P_BIT        = 24;
  localparam int HW_IMM_BIT   = 22;
  localparam int HW_SIGN_BIT  = 6;
  localparam int HW_HALF_BIT  = 5;
  localparam int HW_MARK7_BIT = 7;
  localparam int HW_MARK4_BIT = 4;
  localparam int HI_NIB_HI    = 11;
  localparam int HI_NIB_LO    = 8;
  localparam int LO_NIB_HI    = 3;
  localparam int LO_NIB_LO    = 0;

  // Class field encodings
  localparam logic [2:0] CLASS_DP_IMM = 3'h1;
  localparam logic [2:0] CLASS_MISC   = 3'h0;
  localparam logic [2:0] CLASS_SDT_I  = 3'h2;
  localparam logic [2:0] CLASS_SDT_R  = 3'h3;
  localparam logic [2:0] CLASS_BLOCK  = 3'h4;
  localparam logic [2:0] CLASS_BRANCH = 3'h5;
  localparam logic [2:0] CLASS_CP_DT  = 3'h6;
  localparam logic [2:0] CLASS_CP_OP  = 3'h7;

  // Reset values
  localparam logic [31:0] WORD_RST  = 32'h0;
  localparam logic [3:0]  NIB_RST   = 4'h0;
  localparam logic [7:0]  BYTE_RST  = 8'h0;

  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_DATA_PROC,
    KIND_MULTIPLY,
    KIND_HALF_REG,
    KIND_HALF_IMM,
    KIND_SINGLE_XFER,
    KIND_BLOCK_XFER,
    KIND_BRANCH,
    KIND_COPROC,
    KIND_SWI,
    KIND_UNDEFINED
  } insn_kind_e;

endpackage : insn_decode_pkg

// ==== design/imm_rotator.sv ====
`timescale 1ns/100ps
`default_nettype none
module imm_rotator (
  input  wire logic [3:0]  rot_in,
  input  wire logic [7:0]  imm8_in,
  output logic      [31:0] const_out
);

  wire logic [63:0] doubled;
  wire logic [5:0]  amount;

  // Rotate amount is twice the field, so always even
  assign amount    = {1'b0, rot_in, 1'b0};                                     // RQ2
  assign doubled   = {24'h000000, imm8_in, 24'h000000, imm8_in} >> amount;    // RQ2
  assign const_out = doubled[31:0];                                            // RQ2

endmodule : imm_rotator
`default_nettype wire

// ==== design/word_instruction_format_decoder.sv ====
`timescale 1ns/100ps
`default_nettype none
// Operation
// RQ1 - Bits 31..28 of every word give the condition selector.
// RQ2 - Immediate operand is an 8-bit value rotated right by an even count.
// RQ3 - Flag update is signalled only when the S qualifier is set.
// RQ4 - Translation qualifier forces unprivileged access; never with pre-indexed addressing.
// RQ5 - Data processing: opcode 24..21, operand reg 19..16, dest 15..12, operand2 11..0.
// RQ6 - Halfword register offset: 27..25, 22, 11..8 zero; 7 and 4 one.
// RQ7 - Halfword with bit 22 set: immediate offset from nibbles 11..8 and 3..0.
// RQ8 - Unallocated codes such as multiply with bit 6 set must not be fed.
// RQ9 - Class 011 with bit 4 set raises the undefined-instruction exception.
module word_instruction_format_decoder (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        insn_valid_in,
  input  wire logic [31:0] insn_word_in,
  output logic             dec_valid_out,
  output logic [3:0]       condition_out,
  output logic [3:0]       kind_out,
  output logic [3:0]       opcode_out,
  output logic [3:0]       first_operand_register_out,
  output logic [3:0]       dest_register_out,
  output logic [11:0]      operand2_out,
  output logic             imm_operand_out,
  output logic [31:0]      rotated_immediate_constant_out,
  output logic             flag_update_out,
  output logic             force_user_out,
  output logic             half_signed_out,
  output logic             half_size_out,
  output logic [7:0]       half_offset_out,
  output logic             undefined_trap_out
);

  wire logic [31:0] w;
  wire logic [2:0]  cls;
  wire logic        is_dp;
  wire logic        is_mul;
  wire logic        is_swap;
  wire logic        is_bx;
  wire logic        is_half_reg;
  wire logic        is_half_imm;
  wire logic        is_undef;
  wire logic        is_sdt;
  wire logic        dp_imm;
  wire logic        imm_dp;
  wire logic        flag_upd;
  wire logic        force_user;
  wire logic [31:0] rot_const;
  wire logic [7:0]  half_off;
  insn_decode_pkg::insn_kind_e kind_next;

  assign w   = insn_word_in;
  assign cls = w[insn_decode_pkg::CLASS_HI:insn_decode_pkg::CLASS_LO];

  // Multiply patterns with bit 6 set are unallocated; assumed absent, so they fall
  // through as halfword forms, or as data processing when bit 22 is clear and 11..8 nonzero. RQ8
  assign is_mul  = (cls == insn_decode_pkg::CLASS_MISC) && (w[7:4] == 4'h9)
                 && (w[24:23] != 2'h2);
  assign is_swap = (cls == insn_decode_pkg::CLASS_MISC) && (w[24:23] == 2'h2)
                 && (w[21:20] == 2'h0) && (w[11:4] == 8'h09);
  assign is_bx   = (w[27:4] == 24'h12FFF1);
  assign is_half_reg = (cls == insn_decode_pkg::CLASS_MISC)                  // RQ6
                 && !w[insn_decode_pkg::HW_IMM_BIT]                             // RQ6
                 && (w[insn_decode_pkg::HI_NIB_HI:insn_decode_pkg::HI_NIB_LO] == 4'h0) // RQ6
                 && w[insn_decode_pkg::HW_MARK7_BIT] && w[insn_decode_pkg::HW_MARK4_BIT] // RQ6
                 && (w[6:5] != 2'h0);
  assign is_half_imm = (cls == insn_decode_pkg::CLASS_MISC)                  // RQ7
                 && w[insn_decode_pkg::HW_IMM_BIT]                              // RQ7
                 && w[insn_decode_pkg::HW_MARK7_BIT] && w[insn_decode_pkg::HW_MARK4_BIT] // RQ7
                 && (w[6:5] != 2'h0);
  // Reserved pattern traps rather than decoding as a transfer
  assign is_undef = (cls == insn_decode_pkg::CLASS_SDT_R) && w[4];             // RQ9
  assign is_sdt   = ((cls == insn_decode_pkg::CLASS_SDT_I)
                 || (cls == insn_decode_pkg::CLASS_SDT_R)) && !is_undef;
  assign is_dp    = ((cls == insn_decode_pkg::CLASS_DP_IMM)
                 || (cls == insn_decode_pkg::CLASS_MISC))
                 && !is_mul && !is_swap && !is_bx && !is_half_reg && !is_half_imm;
  assign dp_imm   = (cls == insn_decode_pkg::CLASS_DP_IMM);
  // Constant is zero outside immediate data processing so execute never sees stale bits
  assign imm_dp   = is_dp && dp_imm;                                           // RQ2

  // Compare/test opcodes always set flags, S is then mandatory in the encoding
  assign flag_upd = (is_dp || is_mul) && w[insn_decode_pkg::S_BIT];            // RQ3
  // Post-indexed with W set is the translated form; pre-indexed never is
  assign force_user = is_sdt && !w[insn_decode_pkg::P_BIT]                     // RQ4
                    && w[insn_decode_pkg::W_BIT];                              // RQ4
  assign half_off = {w[insn_decode_pkg::HI_NIB_HI:insn_decode_pkg::HI_NIB_LO], // RQ7
                     w[insn_decode_pkg::LO_NIB_HI:insn_decode_pkg::LO_NIB_LO]}; // RQ7

  always_comb begin
    if (is_undef) begin
      kind_next = insn_decode_pkg::KIND_UNDEFINED;
    end else if (is_half_reg) begin
      kind_next = insn_decode_pkg::KIND_HALF_REG;
    end else if (is_half_imm) begin
      kind_next = insn_decode_pkg::KIND_HALF_IMM;
    end else if (is_mul) begin
      kind_next = insn_decode_pkg::KIND_MULTIPLY;
    end else if (is_sdt) begin
      kind_next = insn_decode_pkg::KIND_SINGLE_XFER;
    end else if (is_dp || is_swap || is_bx) begin
      kind_next = is_dp ? insn_decode_pkg::KIND_DATA_PROC : insn_decode_pkg::KIND_BRANCH;
    end else begin
      case (cls)
        insn_decode_pkg::CLASS_BLOCK:  kind_next = insn_decode_pkg::KIND_BLOCK_XFER;
        insn_decode_pkg::CLASS_BRANCH: kind_next = insn_decode_pkg::KIND_BRANCH;
        insn_decode_pkg::CLASS_CP_DT:  kind_next = insn_decode_pkg::KIND_COPROC;
        insn_decode_pkg::CLASS_CP_OP:  kind_next = w[24] ? insn_decode_pkg::KIND_SWI
                                                         : insn_decode_pkg::KIND_COPROC;
        default:                       kind_next = insn_decode_pkg::KIND_NONE;
      endcase
    end
  end

  imm_rotator u_rot (
    .rot_in    (w[insn_decode_pkg::ROT_HI:insn_decode_pkg::ROT_LO]),
    .imm8_in   (w[insn_decode_pkg::IMM8_HI:insn_decode_pkg::IMM8_LO]),
    .const_out (rot_const)
  );

  // One register stage between fetch and execute
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dec_valid_out                  <= 1'b0;
      condition_out                  <= insn_decode_pkg::NIB_RST;
      kind_out                       <= insn_decode_pkg::NIB_RST;
      opcode_out                     <= insn_decode_pkg::NIB_RST;
      first_operand_register_out     <= insn_decode_pkg::NIB_RST;
      dest_register_out              <= insn_decode_pkg::NIB_RST;
      operand2_out                   <= 12'h000;
      imm_operand_out                <= 1'b0;
      rotated_immediate_constant_out <= insn_decode_pkg::WORD_RST;
      flag_update_out                <= 1'b0;
      force_user_out                 <= 1'b0;
      half_signed_out                <= 1'b0;
      half_size_out                  <= 1'b0;
      half_offset_out                <= insn_decode_pkg::BYTE_RST;
      undefined_trap_out             <= 1'b0;
    end else begin
      dec_valid_out                  <= insn_valid_in;
      condition_out                  <= w[insn_decode_pkg::COND_HI:insn_decode_pkg::COND_LO]; // RQ1
      kind_out                       <= kind_next;
      opcode_out                     <= w[insn_decode_pkg::OPCODE_HI:insn_decode_pkg::OPCODE_LO]; // RQ5
      first_operand_register_out     <= w[insn_decode_pkg::RN_HI:insn_decode_pkg::RN_LO]; // RQ5
      dest_register_out              <= w[insn_decode_pkg::RD_HI:insn_decode_pkg::RD_LO]; // RQ5
      operand2_out                   <= w[insn_decode_pkg::OP2_HI:insn_decode_pkg::OP2_LO]; // RQ5
      imm_operand_out                <= imm_dp; // RQ2
      rotated_immediate_constant_out <= imm_dp ? rot_const : insn_decode_pkg::WORD_RST; // RQ2
      flag_update_out                <= insn_valid_in && flag_upd; // RQ3
      force_user_out                 <= insn_valid_in && force_user; // RQ4
      half_signed_out                <= w[insn_decode_pkg::HW_SIGN_BIT]; // RQ6
      half_size_out                  <= w[insn_decode_pkg::HW_HALF_BIT]; // RQ6
      half_offset_out                <= is_half_imm ? half_off : insn_decode_pkg::BYTE_RST; // RQ7
      undefined_trap_out             <= insn_valid_in && is_undef; // RQ9
    end
  end

  cond_field_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ1
    1'b1 |=> condition_out == $past(insn_word_in[31:28])) else $error("condition field wrong");
  imm_even_rot_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ2
    (insn_word_in[27:25] == 3'h1 && insn_valid_in && insn_word_in[11:0] == 12'h1FF) |=>
    rotated_immediate_constant_out == 32'hC000003F) else $error("rotated constant wrong");
  // Non-immediate forms must present a zero constant
  imm_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ2
    (insn_word_in[27:25] != 3'h1) |=>
    rotated_immediate_constant_out == 32'h00000000 && !imm_operand_out)
    else $error("constant without immediate form");
  flag_qual_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ3
    flag_update_out |-> $past(insn_word_in[20]) && dec_valid_out) else $error("flag update without S");
  flag_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ3
    (insn_valid_in && insn_word_in[27:25] == 3'h1 && !insn_word_in[20]) |=> !flag_update_out)
    else $error("flag update with S clear");
  force_user_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ4
    force_user_out |-> !$past(insn_word_in[24]) && kind_out == 4'h5)
    else $error("translation on pre-index");
  user_pre_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ4
    (insn_word_in[27:26] == 2'h1 && insn_word_in[24]) |=> !force_user_out)
    else $error("pre-indexed transfer translated");
  dp_fields_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ5
    kind_out == 4'h1 |-> {opcode_out, first_operand_register_out, dest_register_out, operand2_out}
    == {$past(insn_word_in[24:21]), $past(insn_word_in[19:0])})
    else $error("data processing fields wrong");
  // Multiply shares class 000 and must not leak into data processing
  mul_kind_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ5
    (insn_word_in[27:22] == 6'h00 && insn_word_in[7:4] == 4'h9) |=> kind_out == 4'h2)
    else $error("multiply decoded as other class");
  half_reg_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ6
    kind_out == 4'h3 |-> $past(insn_word_in[22]) == 1'b0 && $past(insn_word_in[11:8]) == 4'h0
    && $past(insn_word_in[7]) && $past(insn_word_in[4])) else $error("halfword register form wrong");
  half_imm_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ7
    kind_out == 4'h4 |-> half_offset_out == {$past(insn_word_in[11:8]), $past(insn_word_in[3:0])})
    else $error("halfword offset wrong");
  half_off_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ7
    kind_out != 4'h4 |-> half_offset_out == 8'h00) else $error("offset outside halfword form");
  undef_trap_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ9
    (insn_valid_in && insn_word_in[27:25] == 3'h3 && insn_word_in[4]) |=>
    undefined_trap_out && kind_out == 4'hA) else $error("reserved pattern not trapped");
  // Bit 4 clear keeps class 011 an ordinary register offset transfer
  trap_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RQ9
    (insn_word_in[27:25] == 3'h3 && !insn_word_in[4]) |=>
    !undefined_trap_out && kind_out == 4'h5) else $error("transfer trapped wrongly");

endmodule : word_instruction_format_decoder
`default_nettype wire

// ==== test/fetch_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        send_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] word_in,
  output logic             insn_valid_out,
  output logic      [31:0] insn_word_out
);
  // Idle bus flips every cycle so a stale word never passes for a fresh one
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      insn_valid_out <= 1'h0;
      insn_word_out  <= 32'h0;
    end else if (send_in) begin
      insn_valid_out <= valid_in;
      insn_word_out  <= word_in;
    end else begin
      insn_valid_out <= 1'h0;
      insn_word_out  <= ~insn_word_out;
    end
  end
endmodule : fetch_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk_sys_in = 1'h0;
  logic        rst_n_in   = 1'h0;
  logic        send       = 1'h0;
  logic        vld        = 1'h0;
  logic [31:0] word       = 32'h0;
  logic        iv, dv, imm, fu, fuser, hs, hh, trap;
  logic [31:0] iw, kc;
  logic [3:0]  cond, kind, opc, rn, rd;
  logic [11:0] op2;
  logic [7:0]  hoff;
  int          failures   = 0;
  int          tests_run  = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  fetch_model i_fetch_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .send_in(send), .valid_in(vld), .word_in(word),
    .insn_valid_out(iv), .insn_word_out(iw));

  word_instruction_format_decoder i_word_instruction_format_decoder (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .insn_valid_in(iv),
    .insn_word_in(iw), .dec_valid_out(dv), .condition_out(cond),
    .kind_out(kind), .opcode_out(opc), .first_operand_register_out(rn),
    .dest_register_out(rd), .operand2_out(op2), .imm_operand_out(imm),
    .rotated_immediate_constant_out(kc), .flag_update_out(fu),
    .force_user_out(fuser), .half_signed_out(hs), .half_size_out(hh),
    .half_offset_out(hoff), .undefined_trap_out(trap));

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: field %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  // Fixed latency: model presents one edge on, decoder answers one edge later
  task issue(input logic [31:0] w, input logic v);
    @(posedge clk_sys_in);
    send <= 1'h1;
    vld  <= v;
    word <= w;
    @(posedge clk_sys_in);
    send <= 1'h0;
    @(posedge clk_sys_in);
    #1;
  endtask : issue

  task t_dp;
    issue(32'h52937101, 1'h1);
    cmp(cond, 4'h5);
    cmp(opc, 4'h4);
    cmp(rn, 4'h3);
    cmp(rd, 4'h7);
    cmp(op2, 12'h101);
    cmp(kind, 4'h1);
    cmp_bit(imm, 1'h1);
    cmp(kc, 32'h40000000);
    cmp_bit(fu, 1'h1);
    issue(32'hE3A01FFF, 1'h1);
    cmp(kc, 32'h000003FC);
    cmp_bit(fu, 1'h0);
    issue(32'hE3B001FF, 1'h1);
    cmp(kc, 32'hC000003F);
    cmp_bit(fu, 1'h1);
  endtask : t_dp

  // Multiply, swap, exchange, block, branch, coprocessor and SWI forms must stay out of data processing
  task t_kinds;
    issue(32'hE0130291, 1'h1);
    cmp(kind, 4'h2);
    cmp_bit(fu, 1'h1);
    cmp_bit(imm, 1'h0);
    cmp(kc, 32'h00000000);
    issue(32'hE1012091, 1'h1);
    cmp(kind, 4'h7);
    cmp_bit(fu, 1'h0);
    issue(32'hE12FFF11, 1'h1);
    cmp(kind, 4'h7);
    issue(32'hE8BD0003, 1'h1);
    cmp(kind, 4'h6);
    issue(32'hEA000000, 1'h1);
    cmp(kind, 4'h7);
    issue(32'hED900100, 1'h1);
    cmp(kind, 4'h8);
    issue(32'hEF000000, 1'h1);
    cmp(kind, 4'h9);
    cmp_bit(fu, 1'h0);
  endtask : t_kinds

  task t_half;
    issue(32'hA19240F5, 1'h1);
    cmp(kind, 4'h3);
    cmp_bit(hs, 1'h1);
    cmp_bit(hh, 1'h1);
    cmp(hoff, 8'h00);
    issue(32'hA1D24AB6, 1'h1);
    cmp(kind, 4'h4);
    cmp(hoff, 8'hA6);
    cmp_bit(hs, 1'h0);
  endtask : t_half

  task t_xfer;
    issue(32'hE4B12004, 1'h1);
    cmp(kind, 4'h5);
    cmp_bit(fuser, 1'h1);
    issue(32'hE5B12004, 1'h1);
    cmp_bit(fuser, 1'h0);
    issue(32'hE7912003, 1'h1);
    cmp_bit(trap, 1'h0);
    issue(32'hE7912013, 1'h1);
    cmp(kind, 4'hA);
    cmp_bit(trap, 1'h1);
  endtask : t_xfer

  // Qualifiers must stay quiet when the word is not marked present
  task t_invalid;
    issue(32'h52937101, 1'h0);
    cmp_bit(dv, 1'h0);
    cmp_bit(fu, 1'h0);
    issue(32'hE7912013, 1'h0);
    cmp_bit(trap, 1'h0);
  endtask : t_invalid

  task t_cond;
    for (int i = 0; i < 16; i++) begin
      issue({i[3:0], 28'h3A00000}, 1'h1);
      cmp(cond, i[3:0]);
    end
  endtask : t_cond

  task t_b2b;
    @(posedge clk_sys_in);
    send <= 1'h1;
    vld  <= 1'h1;
    word <= 32'hE4B12004;
    @(posedge clk_sys_in);
    word <= 32'hE5B12004;
    @(posedge clk_sys_in);
    send <= 1'h0;
    #1;
    cmp_bit(fuser, 1'h1);
    @(posedge clk_sys_in);
    #1;
    cmp_bit(fuser, 1'h0);
  endtask : t_b2b

  task t_reset;
    @(posedge clk_sys_in);
    rst_n_in <= 1'h0;
    #1;
    cmp_bit(dv, 1'h0);
    cmp(kind, 4'h0);
    @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
  endtask : t_reset

  task end_of_test;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #1000000;
    failures++;
    end_of_test;
  end

  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    t_dp;
    t_kinds;
    t_half;
    t_xfer;
    t_invalid;
    t_cond;
    t_b2b;
    t_reset;
    t_dp;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
